/* hdl/fess_params.svh */
// Constants for the flash erase/suspend command sequencer.
// Included by the sequencer; definitions only.
`ifndef FESS_PARAMS_SVH
`define FESS_PARAMS_SVH
`define FESS_CMD_PGM_SUSP 16'h0051
`define FESS_CMD_PGM_RES 16'h0050
`define FESS_CMD_SETUP 16'h0080
`define FESS_CMD_SEC_ERASE 16'h0030
`define FESS_CMD_CHIP_ERASE 16'h0010
`define FESS_CMD_ERS_SUSP 16'h00B0
`define FESS_CMD_ERS_RES 16'h0030
`define FESS_CMD_PGM_START 16'h00A0
`define FESS_OFS_555 12'h555
`define FESS_OFS_2AA 12'h2AA
`define FESS_OFS_000 12'h000
`define FESS_ERASED_WORD 16'hFFFF
`define FESS_ZERO_WORD 16'h0000
`define FESS_LAST_SEC 8'hFF
`define FESS_BOOT_SEC 8'h00
`define FESS_CLK_NS 25
`define FESS_PSL_NS 5000
`define FESS_ESL_NS 20000
`define FESS_PSL_CYC ((`FESS_PSL_NS) / (`FESS_CLK_NS))
`define FESS_ESL_CYC ((`FESS_ESL_NS) / (`FESS_CLK_NS))
`endif

/* hdl/fess_pkg.sv */
// Types for the flash erase/suspend command sequencer.
// Constants come from fess_params.svh.
`default_nettype none
package fess_pkg;
  typedef enum logic [3:0] {
    FESS_IDLE,
    FESS_SETUP,
    FESS_PGM_ARM,
    FESS_PGM,
    FESS_PGM_SUSP,
    FESS_SE_PRE,
    FESS_SE_ERASE,
    FESS_SE_SUSP_WAIT,
    FESS_ERS_SUSP,
    FESS_CE_PRE,
    FESS_CE_ERASE,
    FESS_PGM_SUSP_WAIT
  } fess_state_t;

  // One host command cycle
  typedef struct packed {
    logic valid;
    logic [7:0] sector;
    logic [11:0] offset;
    logic [15:0] data;
  } fess_cmd_t;

  // Status seen by software through the status read path
  typedef struct packed {
    logic busy;
    logic pgm_active;
    logic pgm_suspended;
    logic ers_active;
    logic ers_suspended;
    logic chip_erase;
    logic seq_abort;
  } fess_status_t;

  // Array side request to the memory core
  typedef struct packed {
    logic wr;
    logic [7:0] sector;
    logic [11:0] offset;
    logic [15:0] data;
  } fess_array_t;

  typedef struct packed {
    fess_state_t st;
    fess_state_t ret;
    logic [7:0] ers_sec;
    logic [7:0] pgm_sec;
    logic [11:0] pgm_ofs;
    logic [15:0] pgm_dat;
    logic [7:0] sec1;
    logic [11:0] idx;
    logic [31:0] cnt;
    logic pgm_in_ers;
    logic abort;
    fess_array_t arr;
  } fess_regs_t;
endpackage
`default_nettype wire

/* hdl/fess_seq.sv */
// Command sequencer for a NOR flash: program suspend/resume,
// sector and chip erase, erase suspend/resume.
// Assumes command cycles arrive already decoded and synchronous to mclk;
// the array core answers reads combinationally from the sector/offset given.
// Sector lock state arrives as level vectors; lock commands live elsewhere.
// Latency and length parameters are counted in mclk cycles.
// Behaviour
// R1: Program suspend 0051h halts programming within the latency; address ignored.
// R2: While program-suspended, reads of other sectors are served.
// R3: Program suspend accepted inside erase-suspend; reads avoid both suspended sectors.
// R4: Program resume 0050h at offset 000h returns to programming.
// R5: Only resume leaves program-suspend; extra resumes ignored; suspend allowed again.
// R6: Host starts sector erase with 0080h at 555h then 0030h at 2AA.
// R7: Sector erase needs matching sectors, right offsets, unlocked, not range locked.
// R8: Erase preprograms to zero then erases; erased words read FFFFh.
// R9: Sector erase ends in idle with addresses released; other banks readable.
// R10: During sector erase only outside reads, status and erase suspend count.
// R11: Hardware reset ends erase at once; host reissues the sequence.
// R12: Host starts chip erase with 0080h at 555h then 0010h at 2AA.
// R13: Chip erase needs consistent addresses, sector 0 unlocked, no range lock.
// R14: Chip erase refuses array reads; only status reads and reset count.
// R15: Chip erase ends in idle, addresses released, all words FFFFh.
// R16: Erase suspend works only during sector erase, ignored in chip erase.
// R17: Erase suspend stops within the latency; bank enters erase-suspend mode.
// R18: Erase-suspended sector reads undefined; status tells erasing from suspended.
// R19: Program finished in erase-suspend returns to erase-suspend, not idle.
// R20: Erase resume continues erasing; repeats ignored; new suspend then accepted.
// R21: Host sends erase suspend as one 00B0h write in the bank.
// R22: Host sends erase resume as 0030h at offset 000h.
// R23: A mismatching cycle abandons the sequence and returns to the prior state.
`include "fess_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fess_seq #(
  parameter int WORDS = 4096,
  parameter int PGM_CYC = 200,
  parameter int PSL_CYC = `FESS_PSL_CYC,
  parameter int ESL_CYC = `FESS_ESL_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire fess_pkg::fess_cmd_t cmd,
  input wire logic rd_req,
  input wire logic [7:0] rd_sector,
  input wire logic [255:0] sec_unlocked,
  input wire logic [255:0] sec_range_locked,
  input wire logic core_done,
  output logic rd_ok,
  output logic rd_undefined,
  output var fess_pkg::fess_status_t status,
  output var fess_pkg::fess_array_t arr
);
  fess_pkg::fess_regs_t r_r;
  fess_pkg::fess_regs_t r_nxt;

  // Sector may be erased: unlocked and outside any lock range
  function automatic logic sec_free(input logic [7:0] s, input logic [255:0] ul, input logic [255:0] rl);
    sec_free = ul[s] & ~rl[s];
  endfunction

  // Command cycle matcher
  function automatic logic is_cmd(input fess_pkg::fess_cmd_t c, input logic [15:0] d);
    is_cmd = c.valid & (c.data == d);
  endfunction

  // Single-cycle suspend and resume decodes; suspends ignore the address
  logic wr_pgm_susp;
  logic wr_pgm_res;
  logic wr_ers_susp;
  logic wr_ers_res;
  assign wr_pgm_susp = is_cmd(cmd, `FESS_CMD_PGM_SUSP); // R1
  assign wr_pgm_res = is_cmd(cmd, `FESS_CMD_PGM_RES) & (cmd.offset == `FESS_OFS_000); // R4
  assign wr_ers_susp = is_cmd(cmd, `FESS_CMD_ERS_SUSP); // R21
  assign wr_ers_res = is_cmd(cmd, `FESS_CMD_ERS_RES) & (cmd.offset == `FESS_OFS_000); // R22

  // Next-state logic; all other writes in busy states fall through untouched
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.arr.wr = 1'b0;
    case (r_r.st)
      // Erase setup only from idle; program start also from suspend; erase resume only from suspend
      fess_pkg::FESS_IDLE, fess_pkg::FESS_ERS_SUSP:
      begin
        if (cmd.valid & (cmd.data == `FESS_CMD_SETUP) & (cmd.offset == `FESS_OFS_555)
            & (r_r.st == fess_pkg::FESS_IDLE))
        begin
          r_nxt.st = fess_pkg::FESS_SETUP;
          r_nxt.sec1 = cmd.sector;
          r_nxt.abort = 1'b0;
        end
        else if (is_cmd(cmd, `FESS_CMD_PGM_START))
        begin
          // Return path is the suspend flag; ret keeps the erase resume point
          r_nxt.pgm_in_ers = (r_r.st == fess_pkg::FESS_ERS_SUSP);
          r_nxt.st = fess_pkg::FESS_PGM_ARM;
        end
        else if ((r_r.st == fess_pkg::FESS_ERS_SUSP) & wr_ers_res)
        begin
          // Resume where the suspend hit; a cut preprogram restarts, zeros again are harmless
          r_nxt.st = r_r.ret; // R20
          if (r_r.ret == fess_pkg::FESS_SE_PRE)
          begin
            r_nxt.idx = '0;
          end
        end
      end

      // Program word write follows the start code
      fess_pkg::FESS_PGM_ARM:
      begin
        // Next write is the program address/data
        if (cmd.valid)
        begin
          r_nxt.pgm_sec = cmd.sector;
          r_nxt.pgm_ofs = cmd.offset;
          r_nxt.pgm_dat = cmd.data;
          r_nxt.cnt = 32'(PGM_CYC);
          r_nxt.st = fess_pkg::FESS_PGM;
        end
      end

      // Second erase cycle: anything but a matching erase code abandons the setup
      fess_pkg::FESS_SETUP:
      begin
        if (cmd.valid)
        begin
          // Assume a mismatch; a good erase code overrides below
          r_nxt.st = r_r.ret; // R23
          r_nxt.abort = 1'b1;
          if ((cmd.offset == `FESS_OFS_2AA) & (cmd.data == `FESS_CMD_SEC_ERASE) & (cmd.sector == r_r.sec1)
              & sec_free(cmd.sector, sec_unlocked, sec_range_locked)) // R7
          begin
            r_nxt.st = fess_pkg::FESS_SE_PRE;
            r_nxt.ers_sec = cmd.sector;
            r_nxt.idx = '0;
            r_nxt.abort = 1'b0;
          end
          else if ((cmd.offset == `FESS_OFS_2AA) & (cmd.data == `FESS_CMD_CHIP_ERASE)
                   & (cmd.sector == r_r.sec1) & sec_unlocked[`FESS_BOOT_SEC] & ~(|sec_range_locked)) // R13
          begin
            r_nxt.st = fess_pkg::FESS_CE_PRE;
            r_nxt.ers_sec = '0;
            r_nxt.idx = '0;
            r_nxt.abort = 1'b0;
          end
        end
      end

      // Embedded program counts down; suspend freezes the count
      fess_pkg::FESS_PGM:
      begin
        r_nxt.cnt = r_r.cnt - 32'd1;
        if (wr_pgm_susp) // R1
        begin
          r_nxt.st = fess_pkg::FESS_PGM_SUSP_WAIT;
          r_nxt.cnt = r_r.cnt;
          r_nxt.idx = 12'(PSL_CYC - 1);
        end
        else if (r_r.cnt == 32'd1)
        begin
          r_nxt.arr = '{wr: 1'b1, sector: r_r.pgm_sec, offset: r_r.pgm_ofs, data: r_r.pgm_dat};
          r_nxt.st = r_r.pgm_in_ers ? fess_pkg::FESS_ERS_SUSP : fess_pkg::FESS_IDLE; // R19
          r_nxt.pgm_in_ers = 1'b0;
        end
      end

      fess_pkg::FESS_PGM_SUSP_WAIT:
      begin
        // Holds for the full suspend latency, PSL_CYC cycles, before reporting suspended
        r_nxt.idx = r_r.idx - 12'd1;
        if (r_r.idx == 12'd0)
        begin
          r_nxt.st = fess_pkg::FESS_PGM_SUSP;
        end
      end

      // Only a resume at offset 000h leaves; other writes fall through
      fess_pkg::FESS_PGM_SUSP:
      begin
        if (wr_pgm_res)
        begin
          r_nxt.st = fess_pkg::FESS_PGM; // R4 R5
        end
      end

      fess_pkg::FESS_SE_PRE, fess_pkg::FESS_CE_PRE:
      begin
        // Preprogram every word to zero before the electrical erase
        r_nxt.arr = '{wr: 1'b1, sector: r_r.ers_sec, offset: r_r.idx, data: `FESS_ZERO_WORD}; // R8
        r_nxt.idx = r_r.idx + 12'd1;
        if (r_r.idx == 12'(WORDS - 1))
        begin
          r_nxt.idx = '0;
          r_nxt.st = (r_r.st == fess_pkg::FESS_SE_PRE) ? fess_pkg::FESS_SE_ERASE : fess_pkg::FESS_CE_ERASE;
        end
        // Chip erase walks every sector before the electrical erase
        if ((r_r.st == fess_pkg::FESS_CE_PRE) & (r_r.idx == 12'(WORDS - 1)))
        begin
          r_nxt.ers_sec = r_r.ers_sec + 8'd1;
          r_nxt.st = (r_r.ers_sec == `FESS_LAST_SEC) ? fess_pkg::FESS_CE_ERASE : fess_pkg::FESS_CE_PRE;
        end
        // Preprogram is part of the sector erase, so suspend is taken here too
        if ((r_r.st == fess_pkg::FESS_SE_PRE) & wr_ers_susp) // R17
        begin
          r_nxt.st = fess_pkg::FESS_SE_SUSP_WAIT;
          r_nxt.cnt = 32'(ESL_CYC - 1);
          r_nxt.ret = fess_pkg::FESS_SE_PRE;
        end
      end

      // Electrical erase; waits for the core, only suspend is taken
      fess_pkg::FESS_SE_ERASE:
      begin
        if (wr_ers_susp) // R10 R16
        begin
          r_nxt.st = fess_pkg::FESS_SE_SUSP_WAIT;
          r_nxt.cnt = 32'(ESL_CYC - 1);
          r_nxt.ret = fess_pkg::FESS_SE_ERASE;
        end
        else if (core_done)
        begin
          r_nxt.st = fess_pkg::FESS_IDLE; // R9
          r_nxt.ers_sec = '0;
        end
      end

      // Suspend latency countdown; erase state is held while it runs
      fess_pkg::FESS_SE_SUSP_WAIT:
      begin
        r_nxt.cnt = r_r.cnt - 32'd1;
        if (r_r.cnt == 32'd0)
        begin
          r_nxt.st = fess_pkg::FESS_ERS_SUSP; // R17
        end
      end

      fess_pkg::FESS_CE_ERASE:
      begin
        // Suspend and every other command are ignored here
        if (core_done)
        begin
          r_nxt.st = fess_pkg::FESS_IDLE; // R14 R15 R16
          r_nxt.ers_sec = '0;
        end
      end

      // Unused codes fall back to idle rather than lock up
      default:
      begin
        r_nxt.st = fess_pkg::FESS_IDLE;
      end
    endcase
    // Remember where an abandoned setup goes back to
    if (r_nxt.st == fess_pkg::FESS_SETUP)
    begin
      r_nxt.ret = r_r.st == fess_pkg::FESS_SETUP ? r_r.ret : r_r.st;
    end
  end

  // Reset ends any operation at once and returns to idle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      r_r <= '{st: fess_pkg::FESS_IDLE, ret: fess_pkg::FESS_IDLE, default: '0}; // R11
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // Read gating: chip erase blocks all, otherwise program-suspended or busy sectors
  // Busy sector reads are refused, not stalled; the host polls status
  logic busy_sec;
  logic pgm_busy;
  always_comb
  begin
    pgm_busy = (r_r.st == fess_pkg::FESS_PGM) | (r_r.st == fess_pkg::FESS_PGM_SUSP)
               | (r_r.st == fess_pkg::FESS_PGM_SUSP_WAIT);
    busy_sec = (pgm_busy & (rd_sector == r_r.pgm_sec)) // R2 R3
               | ((r_r.st == fess_pkg::FESS_SE_PRE) | (r_r.st == fess_pkg::FESS_SE_ERASE)
                  | (r_r.st == fess_pkg::FESS_SE_SUSP_WAIT)) & (rd_sector == r_r.ers_sec); // R9 R10
    rd_ok = rd_req & ~busy_sec & (r_r.st != fess_pkg::FESS_CE_PRE) & (r_r.st != fess_pkg::FESS_CE_ERASE); // R14
    rd_undefined = rd_req & (r_r.st == fess_pkg::FESS_ERS_SUSP | r_r.pgm_in_ers)
                   & (rd_sector == r_r.ers_sec); // R18
  end

  // Status view
  always_comb
  begin
    status.pgm_active = (r_r.st == fess_pkg::FESS_PGM) | (r_r.st == fess_pkg::FESS_PGM_SUSP_WAIT);
    status.pgm_suspended = (r_r.st == fess_pkg::FESS_PGM_SUSP);
    // Chip erase first: the erase and busy flags are built from it
    status.chip_erase = (r_r.st == fess_pkg::FESS_CE_PRE) | (r_r.st == fess_pkg::FESS_CE_ERASE);
    status.ers_active = (r_r.st == fess_pkg::FESS_SE_PRE) | (r_r.st == fess_pkg::FESS_SE_ERASE)
                        | (r_r.st == fess_pkg::FESS_SE_SUSP_WAIT) | status.chip_erase;
    status.ers_suspended = (r_r.st == fess_pkg::FESS_ERS_SUSP) | r_r.pgm_in_ers; // R18
    status.busy = status.pgm_active | status.ers_active;
    status.seq_abort = r_r.abort;
  end

  assign arr = r_r.arr;
endmodule
`default_nettype wire

/* sim/fess_host.sv */
// Host controller model issuing flash command write cycles.
// Assumes the bench calls its tasks from one thread only.
`timescale 1ns/1ps
`default_nettype none
module fess_host (
  input wire logic mclk,
  output var fess_pkg::fess_cmd_t cmd
);
  initial cmd = '0;
  // One valid cycle per write; idle fields carry inverted junk
  task automatic wr(input logic [7:0] s, input logic [11:0] o, input logic [15:0] d);
    @(negedge mclk);
    cmd <= '{1'b1, s, o, d};
    @(negedge mclk);
    cmd <= '{1'b0, ~s, ~o, ~d};
  endtask
  // Erase start: setup at 555h, then the erase code
  task automatic ers(input logic [7:0] s1, input logic [7:0] s2, input logic [11:0] o2, input logic [15:0] d2);
    wr(s1, 12'h555, 16'h0080);
    wr(s2, o2, d2);
  endtask
endmodule
`default_nettype wire

/* sim/fess_seq_sva.sv */
// Port-level assertions for the erase/suspend sequencer.
// Bound into fess_seq below; latencies follow the instance.
`timescale 1ns/1ps
`default_nettype none
module fess_seq_sva #(
  parameter int PSL_CYC = 3,
  parameter int ESL_CYC = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire fess_pkg::fess_cmd_t cmd,
  input wire logic rd_req,
  input wire logic [7:0] rd_sector,
  input wire logic [255:0] sec_unlocked,
  input wire logic [255:0] sec_range_locked,
  input wire logic core_done,
  input wire logic rd_ok,
  input wire logic rd_undefined,
  input wire fess_pkg::fess_status_t status,
  input wire fess_pkg::fess_array_t arr
);
  // Slack over the latency covers the state hop
  localparam int PSL_MAX = PSL_CYC + 3;
  localparam int ESL_MAX = ESL_CYC + 3;
  logic wr_ps, wr_pr, wr_es, wr_er, wr_se, wr_ce, wr_pg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Command decodes
  assign wr_ps = cmd.valid && cmd.data == 16'h0051;
  assign wr_pr = cmd.valid && cmd.data == 16'h0050 && cmd.offset == 12'h000;
  assign wr_es = cmd.valid && cmd.data == 16'h00B0;
  assign wr_er = cmd.valid && cmd.data == 16'h0030 && cmd.offset == 12'h000;
  assign wr_se = cmd.valid && cmd.data == 16'h0030 && cmd.offset == 12'h2AA;
  assign wr_ce = cmd.valid && cmd.data == 16'h0010;
  assign wr_pg = cmd.valid && cmd.data == 16'h00A0;
  // Program start armed: the next valid write is a program word, not a command
  logic pg_armed_r;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pg_armed_r <= 1'b0;
    else if (cmd.valid)
      pg_armed_r <= wr_pg && !pg_armed_r && !status.busy && !status.pgm_suspended;
  end
  a_pgm_susp_time: assert property (status.pgm_active && wr_ps |-> ##[1:PSL_MAX] status.pgm_suspended)
    else $error("program suspend too slow");
  a_pgm_resume: assert property (status.pgm_suspended && wr_pr |-> ##[1:2] status.pgm_active)
    else $error("program resume not taken");
  a_ers_susp_time: assert property (status.ers_active && !status.chip_erase && wr_es |-> ##[1:ESL_MAX] status.ers_suspended)
    else $error("erase suspend too slow");
  a_chip_no_susp: assert property (status.chip_erase && wr_es |=> !status.ers_suspended [*4])
    else $error("chip erase was suspended");
  a_chip_no_read: assert property (status.chip_erase && rd_req |-> !rd_ok)
    else $error("read served in chip erase");
  a_undef_read: assert property (rd_undefined |-> status.ers_suspended)
    else $error("undefined read outside suspend");
  a_preprog_zero: assert property (status.ers_active && arr.wr |-> arr.data == 16'h0000)
    else $error("preprogram word not zero");
  a_ers_done: assert property ((status.ers_active || status.chip_erase) && core_done |=> !status.busy)
    else $error("erase end not idle");
  a_se_locked: assert property (!(status.ers_active || status.ers_suspended) && wr_se && !sec_unlocked[cmd.sector]
    |=> !status.ers_active [*2]) else $error("locked sector erased");
  a_chip_locked: assert property (!status.chip_erase && wr_ce && |sec_range_locked |=> !status.chip_erase [*2])
    else $error("chip erase despite range lock");
  a_se_ignore: assert property (status.ers_active && !status.chip_erase && wr_pg |=> !status.pgm_active [*3])
    else $error("program started mid erase");
  a_ers_resume: assert property (status.ers_suspended && !(status.pgm_active || status.pgm_suspended)
    && wr_er && !pg_armed_r |-> ##[1:2] status.ers_active) else $error("erase resume not taken");
endmodule
bind fess_seq fess_seq_sva #(.PSL_CYC(PSL_CYC), .ESL_CYC(ESL_CYC)) fess_seq_sva_inst (
  .mclk(mclk), .rst(rst), .cmd(cmd), .rd_req(rd_req), .rd_sector(rd_sector), .sec_unlocked(sec_unlocked),
  .sec_range_locked(sec_range_locked), .core_done(core_done), .rd_ok(rd_ok), .rd_undefined(rd_undefined),
  .status(status), .arr(arr));
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the erase/suspend sequencer.
// Assumes fess_host sends commands; the bench plays the array core.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("[FAIL] %s exp %h got %h", n, e, g); \
    end \
  end
`define WAITC(c) for (int k = 0; k < 40 && !(c); k++) @(negedge mclk)
module testbench;
  typedef struct packed {
    logic [7:0] s1, s2;
    logic [11:0] o2;
    logic [15:0] d2;
    logic unl, rl, busy, chip;
  } fess_row_t;
  logic mclk = 0, rst = 1, rd_req = 0, core_done = 0, rd_ok, rd_undefined;
  logic [7:0] rd_sector = 8'h00;
  logic [255:0] sec_unlocked = '1, sec_range_locked = '0;
  fess_pkg::fess_cmd_t cmd;
  fess_pkg::fess_status_t status;
  fess_pkg::fess_array_t arr;
  int fail_count = 0, total_checks = 0, cyc = 0, nwr = 0;
  fess_pkg::fess_array_t last_wr = '0;
  // Erase starts: good, sector mismatch, bad offset, locked, range locked
  fess_row_t rows [8] = '{
    '{8'h05, 8'h05, 12'h2AA, 16'h0030, 1'b1, 1'b0, 1'b1, 1'b0},
    '{8'h05, 8'h06, 12'h2AA, 16'h0030, 1'b1, 1'b0, 1'b0, 1'b0},
    '{8'h05, 8'h05, 12'h2AB, 16'h0030, 1'b1, 1'b0, 1'b0, 1'b0},
    '{8'h05, 8'h05, 12'h2AA, 16'h0030, 1'b0, 1'b0, 1'b0, 1'b0},
    '{8'h05, 8'h05, 12'h2AA, 16'h0030, 1'b1, 1'b1, 1'b0, 1'b0},
    '{8'h00, 8'h00, 12'h2AA, 16'h0010, 1'b1, 1'b0, 1'b1, 1'b1},
    '{8'h00, 8'h00, 12'h2AA, 16'h0010, 1'b1, 1'b1, 1'b0, 1'b0},
    '{8'h00, 8'h00, 12'h2AA, 16'h0010, 1'b0, 1'b0, 1'b0, 1'b0}};
  always #12.5 mclk = ~mclk;
  fess_host fess_host_inst (.mclk(mclk), .cmd(cmd));
  // Short counts keep the run brief
  fess_seq #(.WORDS(4), .PGM_CYC(20), .PSL_CYC(3), .ESL_CYC(3)) fess_seq_inst (
    .mclk(mclk), .rst(rst), .cmd(cmd), .rd_req(rd_req), .rd_sector(rd_sector), .sec_unlocked(sec_unlocked),
    .sec_range_locked(sec_range_locked), .core_done(core_done), .rd_ok(rd_ok), .rd_undefined(rd_undefined),
    .status(status), .arr(arr));
  // Array write pulses, counted mid-cycle
  always @(negedge mclk)
  begin
    if (arr.wr === 1'b1)
    begin
      nwr++;
      last_wr = arr;
    end
  end
  // Hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic note(input string t);
    $display("test %s done, mismatches %0d", t, fail_count);
  endtask
  task automatic do_reset(input int n);
    @(negedge mclk);
    rst = 1;
    repeat (n) @(negedge mclk);
    rst = 0;
  endtask
  // Read request held for one full cycle, output looked at early
  task automatic rd_on(input logic [7:0] s);
    @(negedge mclk);
    rd_req = 1;
    rd_sector = s;
    #1;
  endtask
  task automatic rd_off();
    @(negedge mclk);
    rd_req = 0;
  endtask
  task automatic core_pulse();
    @(negedge mclk);
    core_done = 1;
    @(negedge mclk);
    core_done = 0;
  endtask
  // Program, suspend it, read elsewhere, resume
  task automatic pgm_susp();
    fess_host_inst.wr(8'h00, 12'h555, 16'h00A0);
    fess_host_inst.wr(8'h09, 12'h010, 16'h1234);
    fess_host_inst.wr(8'h33, 12'h777, 16'h0051);
    `WAITC(status.pgm_suspended);
    `CHK("pgm susp", 1'b1, status.pgm_suspended);
    rd_on(8'hC8);
    `CHK("read other", 1'b1, rd_ok);
    rd_sector = 8'h09;
    #1;
    `CHK("read suspended", 1'b0, rd_ok);
    rd_off();
    fess_host_inst.wr(8'h09, 12'h000, 16'h0050);
    fess_host_inst.wr(8'h09, 12'h000, 16'h0050);
    `CHK("resumed", 1'b1, status.pgm_active);
  endtask
  initial
  begin
    repeat (6) @(negedge mclk);
    rst = 0;
    `CHK("reset status", 7'h00, status);
    foreach (rows[i])
    begin
      sec_unlocked = '1;
      sec_range_locked = '0;
      sec_unlocked[rows[i].s1] = rows[i].unl;
      sec_range_locked[rows[i].s1] = rows[i].rl;
      fess_host_inst.ers(rows[i].s1, rows[i].s2, rows[i].o2, rows[i].d2);
      @(negedge mclk);
      `CHK("busy", rows[i].busy, status.busy);
      `CHK("chip", rows[i].chip, status.chip_erase);
      `CHK("abort", ~rows[i].busy, status.seq_abort);
      do_reset(2);
    end
    sec_unlocked = '1;
    sec_range_locked = '0;
    note("table");
    nwr = 0;
    fess_host_inst.ers(8'h05, 8'h05, 12'h2AA, 16'h0030);
    rd_on(8'hC8);
    `CHK("read other bank", 1'b1, rd_ok);
    rd_off();
    fess_host_inst.wr(8'h00, 12'h555, 16'h00A0);
    repeat (10) @(negedge mclk);
    `CHK("no program", 1'b0, status.pgm_active);
    `CHK("preprogram words", 4, nwr);
    core_pulse();
    `CHK("erase idle", 1'b0, status.busy);
    note("sector erase");
    fess_host_inst.ers(8'h05, 8'h05, 12'h2AA, 16'h0030);
    repeat (8) @(negedge mclk);
    fess_host_inst.wr(8'h05, 12'h000, 16'h00B0);
    `WAITC(status.ers_suspended);
    rd_on(8'h05);
    `CHK("undefined read", 1'b1, rd_undefined);
    rd_off();
    pgm_susp();
    `WAITC(!status.pgm_active);
    `CHK("back to suspend", 1'b1, status.ers_suspended);
    fess_host_inst.wr(8'h05, 12'h000, 16'h0030);
    `CHK("program word", {1'b1, 8'h09, 12'h010, 16'h1234}, last_wr);
    fess_host_inst.wr(8'h05, 12'h000, 16'h0030);
    `CHK("erase resumed", 1'b1, status.ers_active);
    fess_host_inst.wr(8'h05, 12'h000, 16'h00B0);
    `WAITC(status.ers_suspended);
    `CHK("resuspend", 1'b1, status.ers_suspended);
    do_reset(2);
    fess_host_inst.ers(8'h05, 8'h05, 12'h2AA, 16'h0030);
    fess_host_inst.wr(8'h05, 12'h000, 16'h00B0);
    `WAITC(status.ers_suspended);
    `CHK("preprogram suspend", 1'b1, status.ers_suspended);
    nwr = 0;
    fess_host_inst.wr(8'h05, 12'h000, 16'h0030);
    repeat (8) @(negedge mclk);
    `CHK("preprogram rerun", 4, nwr);
    core_pulse();
    `CHK("suspend erase idle", 1'b0, status.busy);
    note("erase suspend");
    pgm_susp();
    fess_host_inst.wr(8'h09, 12'h000, 16'h0051);
    `WAITC(status.pgm_suspended);
    `CHK("pgm resuspend", 1'b1, status.pgm_suspended);
    do_reset(2);
    note("program suspend");
    fess_host_inst.ers(8'h00, 8'h00, 12'h2AA, 16'h0010);
    rd_on(8'hC8);
    `CHK("chip read", 1'b0, rd_ok);
    rd_off();
    fess_host_inst.wr(8'h00, 12'h000, 16'h00B0);
    repeat (6) @(negedge mclk);
    `CHK("chip no suspend", 1'b0, status.ers_suspended);
    do_reset(1);
    `CHK("reset ends", 1'b0, status.busy);
    fess_host_inst.ers(8'h00, 8'h00, 12'h2AA, 16'h0010);
    repeat (1100) @(negedge mclk);
    core_pulse();
    `CHK("chip idle", 1'b0, status.busy);
    note("chip erase");
    summarize();
  end
endmodule
`default_nettype wire
